// ===== hdl/tpd_decoder.sv
// Three-phase PWM input decoder top level
//
// Notes on behaviour
// [RULE_01] Register field 00 or 01 selects six-input control.
// [RULE_02] Register field 10 or 11 selects three-input control.
// [RULE_03] Strap at ground or 47k selects compensated six-input; no direct schemes.
// [RULE_04] Strap floating or at supply selects compensated three-input control.
// [RULE_05] Direct schemes skip the compensation delay stage.
// [RULE_06] A gap is inserted before either transistor turns on, all schemes.
// [RULE_07] Six-input: 00/11 off, only low set drives low, only high drives high.
// [RULE_08] Three-input: low input 0 means off, else output follows high input.
// [RULE_09] Controller holds low inputs high if off state is never needed.
// [RULE_10] Strap sampled only at wake; controller sleeps before changing it.
// [RULE_11] Controller drives all command inputs low before changing the field.
// [RULE_12] Controller leaves scheme settings alone during the wake interval.
// [RULE_13] High side may stay on indefinitely, full duty cycle.
// [RULE_14] Any fault pulls the open-drain fault pin low; causes only via registers.
`timescale 1ns/1ps
`include "tpd_map.svh"
module tpd_decoder #(
  parameter int PHASES = 3,
  parameter int GAP_CYC = `TPD_GAP_CYC,
  parameter int COMP_CYC = `TPD_COMP_CYC,
  parameter bit STRAP_VARIANT = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [PHASES-1:0] i_high_side_cmd_input,
  input wire logic [PHASES-1:0] i_low_side_cmd_input,
  input wire logic i_low_power_request_n,
  input wire logic [1:0] i_scheme_strap,
  input wire logic [1:0] i_scheme_field,
  input wire logic i_fault_event,
  output logic [PHASES-1:0] o_phase_high_on,
  output logic [PHASES-1:0] o_phase_low_on,
  output logic [1:0] o_scheme,
  output logic o_fault_indicator_n_o,
  output logic o_fault_indicator_n_oe_n
);
  // Delay line holds eight taps
  if (PHASES < 1 || PHASES > 8 || COMP_CYC < 1 || COMP_CYC > 8)
  begin : g_bad_param
    $error("unsupported parameter");
  end
  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed
  {
    logic [1:0][PHASES-1:0] hs_sync;
    logic [1:0][PHASES-1:0] ls_sync;
    logic [1:0] slp_sync;
    logic [1:0] flt_sync;
    logic [1:0][1:0] strap_sync;
    logic [1:0] field_q;
    logic awake;
    logic [1:0] scheme;
    logic [7:0][PHASES-1:0] hs_dly;
    logic [7:0][PHASES-1:0] ls_dly;
    logic fault_n;
  } tpd_state_t;
  tpd_state_t s_q;
  tpd_state_t s_d;
  tpd_pkg::tpd_cmd_t [PHASES-1:0] cmd;
  tpd_pkg::tpd_drv_t [PHASES-1:0] req;
  tpd_pkg::tpd_gate_t [PHASES-1:0] gate;
  logic direct;
  logic three_in;
  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.hs_sync = {s_q.hs_sync[0], i_high_side_cmd_input};
    s_d.ls_sync = {s_q.ls_sync[0], i_low_side_cmd_input};
    s_d.slp_sync = {s_q.slp_sync[0], i_low_power_request_n};
    s_d.flt_sync = {s_q.flt_sync[0], i_fault_event};
    s_d.strap_sync = {s_q.strap_sync[0], i_scheme_strap};
    s_d.field_q = i_scheme_field;
    s_d.awake = s_q.slp_sync[1];
    s_d.hs_dly = {s_q.hs_dly[6:0], s_q.hs_sync[1]};
    s_d.ls_dly = {s_q.ls_dly[6:0], s_q.ls_sync[1]};
    if (STRAP_VARIANT)
    begin
      // Latched only on wake from sleep
      if (s_q.slp_sync[1] && !s_q.awake) // [RULE_10]
      begin
        if (s_q.strap_sync[1] == `TPD_STRAP_GND || s_q.strap_sync[1] == `TPD_STRAP_R47)
        begin
          s_d.scheme = `TPD_SCHEME_6C; // [RULE_03]
        end
        else
        begin
          s_d.scheme = `TPD_SCHEME_3C; // [RULE_04]
        end
      end
    end
    else
    begin
      // Field bit 1 picks three-input, bit 0 picks direct
      s_d.scheme = s_q.field_q; // [RULE_01] [RULE_02]
    end
    // Open-drain fault pin pulls low on any fault
    s_d.fault_n = !s_q.flt_sync[1]; // [RULE_14]
  end
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_q <= '{default: '0, scheme: `TPD_SCHEME_6C, fault_n: 1'b1};
    end
    else if (i_ce)
    begin
      s_q <= s_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Decode per phase
  assign direct = s_q.scheme[0];
  assign three_in = s_q.scheme[1];
  genvar g;
  generate
    for (g = 0; g < PHASES; g++)
    begin : g_phase
      always_comb
      begin
        // Direct skips the compensation delay
        if (direct) // [RULE_05]
        begin
          cmd[g].hs = s_q.hs_sync[1][g];
          cmd[g].ls = s_q.ls_sync[1][g];
        end
        else
        begin
          cmd[g].hs = s_q.hs_dly[COMP_CYC-1][g];
          cmd[g].ls = s_q.ls_dly[COMP_CYC-1][g];
        end
        if (!s_q.awake)
        begin
          req[g] = tpd_pkg::TPD_OFF;
        end
        else if (three_in)
        begin
          if (!cmd[g].ls) // [RULE_08]
          begin
            req[g] = tpd_pkg::TPD_OFF;
          end
          else
          begin
            req[g] = cmd[g].hs ? tpd_pkg::TPD_HIGH : tpd_pkg::TPD_LOW; // [RULE_08]
          end
        end
        else if (cmd[g].hs == cmd[g].ls) // [RULE_07]
        begin
          req[g] = tpd_pkg::TPD_OFF;
        end
        else
        begin
          req[g] = cmd[g].hs ? tpd_pkg::TPD_HIGH : tpd_pkg::TPD_LOW; // [RULE_07]
        end
      end
      tpd_gap #(
        .GAP_CYC(GAP_CYC)
      ) u_gap (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_req(req[g]),
        .o_gate(gate[g])
      );
      assign o_phase_high_on[g] = gate[g].hs_on;
      assign o_phase_low_on[g] = gate[g].ls_on;
    end
  endgenerate
  assign o_scheme = s_q.scheme;
  assign o_fault_indicator_n_o = 1'b0;
  assign o_fault_indicator_n_oe_n = s_q.fault_n;
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_strap_no_direct: assert property (@(posedge i_clk) disable iff (i_rst)
    STRAP_VARIANT |-> !o_scheme[0]) else $error("direct scheme in strap variant"); // [RULE_03]
  a_strap_held_awake: assert property (@(posedge i_clk) disable iff (i_rst)
    (STRAP_VARIANT && s_q.awake && $past(s_q.awake) && i_ce) |-> $stable(o_scheme))
    else $error("strap relatched while awake"); // [RULE_10]
  a_field_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    (!STRAP_VARIANT && i_ce [*3]) |-> o_scheme == $past(i_scheme_field, 2))
    else $error("scheme not from field"); // [RULE_01]
  a_six_off_equal: assert property (@(posedge i_clk) disable iff (i_rst)
    (!three_in && s_q.awake && cmd[0].hs == cmd[0].ls && i_ce) |=> !o_phase_high_on[0] && !o_phase_low_on[0])
    else $error("six-input equal inputs drove output"); // [RULE_07]
  a_three_off_low: assert property (@(posedge i_clk) disable iff (i_rst)
    (three_in && s_q.awake && !cmd[0].ls && i_ce) |=> !o_phase_high_on[0] && !o_phase_low_on[0])
    else $error("three-input off not honoured"); // [RULE_08]
  a_three_mode: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_scheme[1] && s_q.awake && cmd[0].ls && cmd[0].hs) |-> req[0] == tpd_pkg::TPD_HIGH)
    else $error("three-input scheme not decoded"); // [RULE_02]
  a_fault_pin: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce [*4] ##0 $past(i_fault_event, 3)) |-> !o_fault_indicator_n_oe_n)
    else $error("fault pin not pulled"); // [RULE_14]
  a_high_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_phase_high_on[0] && req[0] == tpd_pkg::TPD_HIGH) |=> o_phase_high_on[0])
    else $error("high side dropped"); // [RULE_13]
  a_direct_path: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce [*3] ##0 direct) |-> cmd[0].hs == $past(i_high_side_cmd_input[0], 2))
    else $error("direct not bypassed"); // [RULE_05]
  c_high_on: cover property (@(posedge i_clk) o_phase_high_on[0]);
  c_low_on: cover property (@(posedge i_clk) o_phase_low_on[0]);
  c_three_in: cover property (@(posedge i_clk) three_in && o_phase_high_on[0]);
  c_fault: cover property (@(posedge i_clk) !o_fault_indicator_n_oe_n);
endmodule : tpd_decoder

// ===== hdl/tpd_gap.sv
// Per-phase shoot-through gap insertion
`timescale 1ns/1ps
`include "tpd_map.svh"
module tpd_gap #(
  parameter int GAP_CYC = `TPD_GAP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input tpd_pkg::tpd_drv_t i_req,
  output tpd_pkg::tpd_gate_t o_gate
);
  // Counter is eight bits wide
  if (GAP_CYC < 1 || GAP_CYC > 255)
  begin : g_bad_gap
    $error("GAP_CYC out of range");
  end
  typedef struct packed
  {
    tpd_pkg::tpd_gap_st_t st;
    tpd_pkg::tpd_drv_t tgt;
    logic [7:0] cnt;
    tpd_pkg::tpd_gate_t gate;
  } tpd_gap_state_t;
  tpd_gap_state_t s_q;
  tpd_gap_state_t s_d;
  always_comb
  begin
    s_d = s_q;
    case (s_q.st)
      tpd_pkg::TPD_GAP_IDLE, tpd_pkg::TPD_GAP_ON:
      begin
        if (i_req != s_q.tgt)
        begin
          // Both transistors off before any turn-on
          s_d.gate = '0; // [RULE_06]
          s_d.tgt = i_req;
          s_d.cnt = 8'(GAP_CYC);
          s_d.st = (i_req == tpd_pkg::TPD_OFF) ? tpd_pkg::TPD_GAP_IDLE : tpd_pkg::TPD_GAP_WAIT;
        end
      end
      tpd_pkg::TPD_GAP_WAIT:
      begin
        if (i_req != s_q.tgt)
        begin
          s_d.tgt = i_req;
          s_d.cnt = 8'(GAP_CYC);
          s_d.st = (i_req == tpd_pkg::TPD_OFF) ? tpd_pkg::TPD_GAP_IDLE : tpd_pkg::TPD_GAP_WAIT;
        end
        else if (s_q.cnt > 8'h01)
        begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
        else
        begin
          // Stays on indefinitely, no refresh
          s_d.gate.hs_on = (s_q.tgt == tpd_pkg::TPD_HIGH); // [RULE_13]
          s_d.gate.ls_on = (s_q.tgt == tpd_pkg::TPD_LOW); // [RULE_06]
          s_d.st = tpd_pkg::TPD_GAP_ON;
        end
      end
      default:
      begin
        s_d.st = tpd_pkg::TPD_GAP_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_q <= '{st: tpd_pkg::TPD_GAP_IDLE, tgt: tpd_pkg::TPD_OFF, cnt: 8'h00, gate: '0};
    end
    else if (i_ce)
    begin
      s_q <= s_d;
    end
  end
  assign o_gate = s_q.gate;
  a_gap_never_both: assert property (@(posedge i_clk) disable iff (i_rst)
    !(o_gate.hs_on && o_gate.ls_on)) else $error("both transistors on"); // [RULE_06]
  a_gap_off_first: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_gate.hs_on) |-> $past(!o_gate.ls_on, 1)) else $error("high side on without gap"); // [RULE_06]
endmodule : tpd_gap

// ===== hdl/tpd_map.svh
// Constants for the three-phase input decoder
`ifndef TPD_MAP_SVH
`define TPD_MAP_SVH
`define TPD_CLK_HZ 50000000
`define TPD_GAP_NS 200
`define TPD_GAP_CYC ((`TPD_GAP_NS * (`TPD_CLK_HZ / 1000000) + 999) / 1000)
`define TPD_COMP_CYC 2
`define TPD_SCHEME_6C 2'h0
`define TPD_SCHEME_6D 2'h1
`define TPD_SCHEME_3C 2'h2
`define TPD_SCHEME_3D 2'h3
`define TPD_STRAP_GND 2'h0
`define TPD_STRAP_R47 2'h1
`define TPD_STRAP_FLT 2'h2
`define TPD_STRAP_VDD 2'h3
`endif

// ===== hdl/tpd_pkg.sv
// Types for the three-phase input decoder
package tpd_pkg;
  typedef enum logic [1:0] {TPD_OFF, TPD_LOW, TPD_HIGH} tpd_drv_t;
  typedef enum logic [1:0] {TPD_GAP_IDLE, TPD_GAP_WAIT, TPD_GAP_ON} tpd_gap_st_t;
  typedef struct packed
  {
    logic hs;
    logic ls;
  } tpd_cmd_t;
  typedef struct packed
  {
    logic hs_on;
    logic ls_on;
  } tpd_gate_t;
endpackage : tpd_pkg

// ===== sim/tpd_ctrl_model.sv
// Controller model driving the decoder command and scheme inputs
`timescale 1ns/1ps
module tpd_ctrl_model (
  input wire logic i_clk,
  output logic [2:0] o_hs,
  output logic [2:0] o_ls,
  output logic [1:0] o_field,
  output logic [1:0] o_strap,
  output logic o_sleep_n
);
  initial
  begin
    o_hs = 3'h0;
    o_ls = 3'h0;
    o_field = 2'h0;
    o_strap = 2'h0;
    o_sleep_n = 1'b1;
  end
  task automatic drive(input logic [2:0] hs, input logic [2:0] ls);
    @(posedge i_clk);
    o_hs <= hs;
    o_ls <= ls;
  endtask : drive
  // Commands low before a scheme change, never during wake
  task automatic set_field(input logic [1:0] f);
    drive(3'h0, 3'h0);
    repeat (4) @(posedge i_clk);
    o_field <= f;
    repeat (4) @(posedge i_clk);
  endtask : set_field
  // Sleep around a strap change
  task automatic set_strap(input logic [1:0] s);
    @(posedge i_clk);
    o_sleep_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_strap <= s;
    repeat (4) @(posedge i_clk);
    o_sleep_n <= 1'b1;
    repeat (8) @(posedge i_clk);
  endtask : set_strap
endmodule : tpd_ctrl_model

// ===== sim/tpd_decoder_tb.sv
// Self-checking bench for the three-phase input decoder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tpd_decoder_tb;
  localparam int GAP = 4;
  localparam int COMP = 2;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_fault_event = 1'b0;
  logic [2:0] hs, ls, hi, lo, hi_s, lo_s;
  logic [1:0] field, strap, scheme, scheme_s;
  logic sleep_n, fo, foe_n, fo_s, foe_n_s;
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 34;
  int lat [2];
  always #10 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////
  tpd_ctrl_model m (.i_clk(i_clk), .o_hs(hs), .o_ls(ls), .o_field(field), .o_strap(strap), .o_sleep_n(sleep_n));
  tpd_decoder #(.PHASES(3), .GAP_CYC(GAP), .COMP_CYC(COMP), .STRAP_VARIANT(1'b0)) uut (.i_clk(i_clk),
    .i_rst(i_rst), .i_ce(i_ce), .i_high_side_cmd_input(hs), .i_low_side_cmd_input(ls),
    .i_low_power_request_n(sleep_n), .i_scheme_strap(strap), .i_scheme_field(field), .i_fault_event(i_fault_event),
    .o_phase_high_on(hi), .o_phase_low_on(lo), .o_scheme(scheme), .o_fault_indicator_n_o(fo),
    .o_fault_indicator_n_oe_n(foe_n));
  tpd_decoder #(.PHASES(3), .GAP_CYC(GAP), .COMP_CYC(COMP), .STRAP_VARIANT(1'b1)) uut_s (.i_clk(i_clk),
    .i_rst(i_rst), .i_ce(i_ce), .i_high_side_cmd_input(hs), .i_low_side_cmd_input(ls),
    .i_low_power_request_n(sleep_n), .i_scheme_strap(strap), .i_scheme_field(field),
    .i_fault_event(i_fault_event), .o_phase_high_on(hi_s), .o_phase_low_on(lo_s), .o_scheme(scheme_s),
    .o_fault_indicator_n_o(fo_s), .o_fault_indicator_n_oe_n(foe_n_s));
  ////////////////////////////////////////////////////////////
  function automatic int exp_drv(input int sch, input int h, input int l);
    if (sch < 2)
      return (h == l) ? 0 : (h ? 2 : 1);
    return l ? (h ? 2 : 1) : 0;
  endfunction : exp_drv
  task automatic check_out(input int sch);
    int e;
    repeat (3 + COMP + GAP + 6) @(posedge i_clk);
    @(negedge i_clk);
    for (int p = 0; p < 3; p++)
    begin
      e = exp_drv(sch, hs[p], ls[p]);
      `CHK("high_on", 1'(e == 2), hi[p])
      `CHK("low_on", 1'(e == 1), lo[p])
    end
  endtask : check_out
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////
  always @(negedge i_clk)
  begin
    if (!i_rst)
    begin
      `CHK("overlap", 3'h0, hi & lo)
      `CHK("overlap_s", 3'h0, hi_s & lo_s)
    end
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (20) @(posedge i_clk);
    for (int s = 0; s < 4; s++)
    begin
      m.set_field(2'(s));
      @(negedge i_clk);
      `CHK("scheme", 2'(s), scheme)
      repeat (8)
      begin
        m.drive(3'($random(seed)), 3'($random(seed)));
        check_out(s);
      end
      m.drive(3'($random(seed)), 3'h7);
      check_out(s);
    end
    for (int s = 0; s < 2; s++)
    begin
      m.set_field(2'(s));
      m.drive(3'h1, 3'h0);
      lat[s] = 0;
      while (hi[0] !== 1'b1 && lat[s] < 60)
      begin
        @(negedge i_clk);
        lat[s]++;
      end
      `CHK("gap_wait", 1'b1, 1'(lat[s] > GAP))
    end
    `CHK("comp_delay", COMP, lat[0] - lat[1])
    m.set_field(2'h0);
    m.drive(3'h7, 3'h0);
    repeat (15)
    begin
      repeat (20) @(negedge i_clk);
      `CHK("full_duty", 3'h7, hi)
    end
    // Clock enable low freezes gates against new commands
    @(posedge i_clk);
    i_ce <= 1'b0;
    m.drive(3'h0, 3'h0);
    repeat (20) @(negedge i_clk);
    `CHK("ce_freeze", 3'h7, hi)
    @(posedge i_clk);
    i_ce <= 1'b1;
    repeat (20) @(negedge i_clk);
    `CHK("ce_resume", 3'h0, hi | lo)
    for (int s = 0; s < 4; s++)
    begin
      m.set_strap(2'(s));
      @(negedge i_clk);
      `CHK("strap_scheme", (s < 2) ? 2'h0 : 2'h2, scheme_s)
    end
    @(posedge i_clk);
    m.o_strap <= 2'h0;
    repeat (10) @(negedge i_clk);
    `CHK("strap_held", 2'h2, scheme_s)
    m.drive(3'h7, 3'h7);
    repeat (20) @(negedge i_clk);
    `CHK("strap_three_high", 3'h7, hi_s)
    `CHK("strap_three_low", 3'h0, lo_s)
    `CHK("six_equal_off", 3'h0, hi | lo)
    m.drive(3'h0, 3'h0);
    repeat (20) @(negedge i_clk);
    `CHK("strap_three_off", 3'h0, hi_s | lo_s)
    @(posedge i_clk);
    i_fault_event <= 1'b1;
    repeat (6) @(negedge i_clk);
    `CHK("fault_oe_n", 1'b0, foe_n)
    `CHK("fault_o", 1'b0, fo)
    `CHK("fault_oe_n_s", 1'b0, foe_n_s)
    `CHK("fault_o_s", 1'b0, fo_s)
    @(posedge i_clk);
    i_fault_event <= 1'b0;
    repeat (6) @(negedge i_clk);
    `CHK("fault_clear", 1'b1, foe_n)
    `CHK("fault_clear_s", 1'b1, foe_n_s)
    report_and_stop();
  end
endmodule : tpd_decoder_tb
